// *** include/bdc_map.svh ***
// Register map, field positions, reset values and timing constants
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH
`define BDC_ADDR_W 8
`define BDC_DATA_W 8
`define BDC_OFF_CTRL 8'h00
`define BDC_OFF_VID 8'h01
`define BDC_OFF_SLEW 8'h02
`define BDC_OFF_STATUS 8'h03
`define BDC_OFF_IRQ_STAT 8'h04
`define BDC_OFF_IRQ_MASK 8'h05
`define BDC_OFF_REF 8'h06
`define BDC_CTRL_EN_LSB 0
`define BDC_CTRL_CCM_LSB 3
`define BDC_VID_GO_BIT 7
`define BDC_REF_BUSY_BIT 7
`define BDC_CTRL_EN_RST 3'h7
`define BDC_CTRL_CCM_RST 3'h0
`define BDC_VID_RST 7'h00
`define BDC_SLEW_RST 3'h0
`define BDC_IRQ_W 6
`define BDC_IRQ_MASK_RST 6'h00
`define BDC_IRQ_OC_LSB 0
`define BDC_IRQ_THERM 3
`define BDC_IRQ_PG_LOST 4
`define BDC_IRQ_VID_DONE 5
`define BDC_CLK_PERIOD_NS 100
`define BDC_SW_PERIOD_NS 2000
`define BDC_SLEW_UNIT_NS 1000
`define BDC_OC_WAIT_SW 256
`define BDC_HICCUP_SW 8192
`define BDC_STRAP_WAIT 3'h4
`define BDC_CNT_W 14
`endif

// *** include/bdc_pkg.sv ***
// Types shared by the converter control block
package bdc_pkg;
`include "bdc_map.svh"
   typedef enum logic [2:0] {
      BDC_CH_OFF = 3'b001,
      BDC_CH_RUN = 3'b010,
      BDC_CH_HICCUP = 3'b100
   } bdc_ch_state_t;
   typedef struct packed {
      logic [`BDC_ADDR_W-1:0] addr;
      logic [`BDC_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bdc_bus_t;
   typedef struct packed {
      logic [2:0] channel_enable_pin;
      logic [2:0] oc;
      logic [2:0] ov;
      logic [2:0] bst_uv;
      logic [2:0] pg;
      logic therm_hot;
      logic therm_cool;
      logic sda;
      logic scl;
      logic sync_clk;
   } bdc_pins_t;
   typedef struct packed {
      logic [2:0] run;
      logic [2:0] hs_off;
      logic [2:0] switch_node_pulldown;
      logic [2:0] continuous_conduction_mode;
      logic [2:0] ss_hold;
   } bdc_ch_out_t;
   typedef struct packed {
      logic [2:0] strap_cnt;
      logic strap_done;
      logic standalone;
      logic touched;
      logic sync_prev;
      logic [7:0] sw_cnt;
      logic ph0;
      logic ph180;
      logic therm_sd;
      bdc_ch_state_t [2:0] ch;
      logic [2:0][`BDC_CNT_W-1:0] cnt;
      logic [2:0] ctrl_en;
      logic [2:0] ctrl_ccm;
      logic [2:0] slew;
      logic [6:0] target;
      logic [6:0] ref_code;
      logic ramping;
      logic [7:0] slew_cnt;
      logic fb_internal;
      logic pg_out;
      logic [`BDC_IRQ_W-1:0] irq_stat;
      logic [`BDC_IRQ_W-1:0] irq_mask;
      logic irq;
      logic [`BDC_DATA_W-1:0] rdata;
      bdc_ch_out_t ch_out;
   } bdc_state_t;
endpackage

// *** rtl/bdc_pin_sync.sv ***
// Three-stage synchroniser for asynchronous pins with agreement filter
`timescale 1ns/1ps
module bdc_pin_sync #(
   parameter int W = 1
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } bdc_sync_state_t;
   bdc_sync_state_t st;
   bdc_sync_state_t next_st;
   always_comb begin
      next_st = st;
      next_st.s1 = D;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // A bit changes only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.q[i] = st.s3[i];
         end
      end
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign Q = st.q;
endmodule // bdc_pin_sync

// *** rtl/bdc_ctrl.sv ***
// Digital control of a three-channel step-down converter with voltage scaling
// Summary of operation
// - A 7-bit code selects one of 128 levels for channel two, 0.68 V up in 10 mV steps.
// - Writing the code alone changes nothing; the level change starts on the trigger bit.
// - Writing the trigger bit as one moves channel two's feedback to the internal divider.
// - Until the trigger bit has been written each channel regulates from its external divider.
// - With both bus lines low at start the bus is ignored and only enable pins rule.
// - The host can enable or disable each channel over the bus, but a channel runs only while its enable pin is also high.
// - Pulse skipping is automatic unless the host forces continuous conduction.
// - Each channel's power-good result is readable by the host.
// - The power-good output is high only with all channels in range and running.
// - Overcurrent for more than 256 switching cycles stops a channel for 8192 cycles.
// - On overvoltage the high-side switch is held off until feedback is back below 105%.
// - Thermal trip stops all channels; they restart through soft-start once cooled.
// - Bootstrap undervoltage pulls the channel's switch node low to recharge.
// - Channel one is clocked 180 degrees out of phase with channels two and three.
// - An external clock locks the switching cycle to its falling edge.
`timescale 1ns/1ps
module bdc_ctrl
   import bdc_pkg::*;
#(
   parameter int SW_PERIOD_CYC = `BDC_SW_PERIOD_NS / `BDC_CLK_PERIOD_NS,
   parameter int SLEW_UNIT_CYC = `BDC_SLEW_UNIT_NS / `BDC_CLK_PERIOD_NS,
   parameter int OC_WAIT_SW = `BDC_OC_WAIT_SW,
   parameter int HICCUP_SW = `BDC_HICCUP_SW
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire bdc_pkg::bdc_bus_t BUS,
   input wire bdc_pkg::bdc_pins_t PINS,
   output logic [`BDC_DATA_W-1:0] RDATA,
   output bdc_pkg::bdc_ch_out_t CH,
   output logic SW_CLK_PH0,
   output logic SW_CLK_PH180,
   output logic [6:0] REF_CODE,
   output logic FB_INTERNAL,
   output logic POWER_GOOD_OUT,
   output logic IRQ,
   output logic STANDALONE
);
   import bdc_pkg::*;

   localparam logic [7:0] SW_LAST = 8'(SW_PERIOD_CYC - 1);
   localparam logic [7:0] SW_HALF = 8'(SW_PERIOD_CYC / 2);
   localparam logic [`BDC_CNT_W-1:0] OC_WAIT = `BDC_CNT_W'(OC_WAIT_SW);
   localparam logic [`BDC_CNT_W-1:0] HICCUP_LAST = `BDC_CNT_W'(HICCUP_SW - 1);

   bdc_state_t st;
   bdc_state_t next_st;
   bdc_pins_t p;
   logic [$bits(bdc_pins_t)-1:0] pins_q;

   bdc_pin_sync #(
      .W($bits(bdc_pins_t))
   ) u_sync (
      .CLK(CLK),
      .RESETN(RESETN),
      .D(PINS),
      .Q(pins_q)
   );

   assign p = bdc_pins_t'(pins_q);

   // Interval between reference steps: slew setting 0..7 gives 1..8 units
   function automatic logic [7:0] slew_limit(input logic [2:0] slew);
      slew_limit = 8'(({5'h00, slew} + 8'h01) * 8'(SLEW_UNIT_CYC) - 8'h01);
   endfunction

   // One code toward the target, never past it
   function automatic logic [6:0] step_toward(input logic [6:0] cur, input logic [6:0] tgt);
      if (cur < tgt) begin
         step_toward = cur + 7'h01;
      end else if (cur > tgt) begin
         step_toward = cur - 7'h01;
      end else begin
         step_toward = cur;
      end
   endfunction

   // Bus enable only counts while the bus is usable
   function automatic logic ch_enable(input logic pin, input logic ok, input logic ctrl);
      ch_enable = pin & (~ok | ctrl);
   endfunction

   logic bus_ok;
   logic sync_fall;
   logic sw_tick;
   logic en;
   logic [2:0] run_n;
   logic [`BDC_IRQ_W-1:0] irq_set;
   logic [`BDC_IRQ_W-1:0] irq_clr;
   logic [6:0] stepped;

   always_comb begin
      next_st = st;
      bus_ok = st.strap_done & ~st.standalone;
      sync_fall = 1'b0;
      sw_tick = 1'b0;
      en = 1'b0;
      run_n = '0;
      irq_set = '0;
      irq_clr = '0;
      stepped = st.ref_code;
      next_st.rdata = '0;
      next_st.ph0 = 1'b0;
      next_st.ph180 = 1'b0;

      // Bus line strap, caught once the synchroniser has settled after reset
      if (!st.strap_done) begin
         if (st.strap_cnt == `BDC_STRAP_WAIT) begin
            next_st.strap_done = 1'b1;
            next_st.standalone = ~p.sda & ~p.scl;
         end else begin
            next_st.strap_cnt = st.strap_cnt + 3'h1;
         end
      end

      // Switching cycle; a falling sync edge restarts it so the phase locks
      sync_fall = st.sync_prev & ~p.sync_clk;
      next_st.sync_prev = p.sync_clk;
      if (sync_fall || st.sw_cnt == SW_LAST) begin
         next_st.sw_cnt = '0;
         next_st.ph0 = 1'b1;
         sw_tick = 1'b1;
      end else begin
         next_st.sw_cnt = st.sw_cnt + 8'h01;
         // Second and third channels share the opposite half-cycle
         next_st.ph180 = (st.sw_cnt + 8'h01) == SW_HALF;
      end

      // Thermal shutdown with hysteresis from the cool comparator
      if (p.therm_hot) begin
         next_st.therm_sd = 1'b1;
         irq_set[`BDC_IRQ_THERM] = ~st.therm_sd;
      end else if (p.therm_cool) begin
         next_st.therm_sd = 1'b0;
      end

      for (int i = 0; i < 3; i++) begin
         // Without a usable bus only the pin decides
         en = ch_enable(p.channel_enable_pin[i], bus_ok, st.ctrl_en[i]);
         unique case (st.ch[i])
            BDC_CH_OFF: begin
               next_st.cnt[i] = '0;
               if (en && !next_st.therm_sd) begin
                  next_st.ch[i] = BDC_CH_RUN;
               end
            end
            BDC_CH_RUN: begin
               if (!en || next_st.therm_sd) begin
                  next_st.ch[i] = BDC_CH_OFF;
               end else if (sw_tick) begin
                  if (!p.oc[i]) begin
                     next_st.cnt[i] = '0;
                  end else if (st.cnt[i] == OC_WAIT) begin
                     // Fault outlasted the wait: stop and start hiccup
                     next_st.ch[i] = BDC_CH_HICCUP;
                     next_st.cnt[i] = '0;
                     irq_set[`BDC_IRQ_OC_LSB + i] = 1'b1;
                  end else begin
                     next_st.cnt[i] = st.cnt[i] + `BDC_CNT_W'(1);
                  end
               end
            end
            BDC_CH_HICCUP: begin
               if (!en || next_st.therm_sd) begin
                  next_st.ch[i] = BDC_CH_OFF;
               end else if (sw_tick) begin
                  if (st.cnt[i] == HICCUP_LAST) begin
                     // Passing through off re-arms soft-start
                     next_st.ch[i] = BDC_CH_OFF;
                  end else begin
                     next_st.cnt[i] = st.cnt[i] + `BDC_CNT_W'(1);
                  end
               end
            end
            default: begin
               next_st.ch[i] = BDC_CH_OFF;
            end
         endcase
         run_n[i] = next_st.ch[i] == BDC_CH_RUN;
         next_st.ch_out.run[i] = run_n[i];
         // Soft-start held in reset while stopped, so every restart ramps
         next_st.ch_out.ss_hold[i] = ~run_n[i];
         next_st.ch_out.hs_off[i] = ~run_n[i] | p.ov[i];
         next_st.ch_out.switch_node_pulldown[i] = run_n[i] & p.bst_uv[i];
         next_st.ch_out.continuous_conduction_mode[i] =
            run_n[i] & bus_ok & st.ctrl_ccm[i];
      end

      // Power good needs every channel in range and running
      next_st.pg_out = (&p.pg) & (&run_n);
      irq_set[`BDC_IRQ_PG_LOST] = st.pg_out & ~next_st.pg_out;

      // Reference ramp, one code per slew interval
      if (st.ramping) begin
         if (st.slew_cnt == slew_limit(st.slew)) begin
            next_st.slew_cnt = '0;
            stepped = step_toward(st.ref_code, st.target);
            next_st.ref_code = stepped;
            if (stepped == st.target) begin
               next_st.ramping = 1'b0;
               irq_set[`BDC_IRQ_VID_DONE] = 1'b1;
            end
         end else begin
            next_st.slew_cnt = st.slew_cnt + 8'h01;
         end
      end

      // Register writes; ignored entirely in standalone operation
      if (BUS.wr && bus_ok) begin
         next_st.touched = 1'b1;
         case (BUS.addr)
            `BDC_OFF_CTRL: begin
               next_st.ctrl_en = BUS.wdata[`BDC_CTRL_EN_LSB +: 3];
               next_st.ctrl_ccm = BUS.wdata[`BDC_CTRL_CCM_LSB +: 3];
            end
            `BDC_OFF_VID: begin
               // Code without the trigger is dropped, level stays put
               if (BUS.wdata[`BDC_VID_GO_BIT]) begin
                  next_st.target = BUS.wdata[6:0];
                  next_st.fb_internal = 1'b1;
                  next_st.ramping = 1'b1;
                  next_st.slew_cnt = '0;
               end
            end
            `BDC_OFF_SLEW: begin
               next_st.slew = BUS.wdata[2:0];
            end
            `BDC_OFF_IRQ_STAT: begin
               irq_clr = BUS.wdata[`BDC_IRQ_W-1:0];
            end
            `BDC_OFF_IRQ_MASK: begin
               next_st.irq_mask = BUS.wdata[`BDC_IRQ_W-1:0];
            end
            default: begin
               next_st.touched = 1'b1;
            end
         endcase
      end

      // Register reads, answered the next cycle only
      if (BUS.rd && bus_ok) begin
         next_st.touched = 1'b1;
         case (BUS.addr)
            `BDC_OFF_CTRL: begin
               next_st.rdata = {2'h0, st.ctrl_ccm, st.ctrl_en};
            end
            `BDC_OFF_VID: begin
               next_st.rdata = {1'b0, st.target};
            end
            `BDC_OFF_SLEW: begin
               next_st.rdata = {5'h00, st.slew};
            end
            `BDC_OFF_STATUS: begin
               next_st.rdata = {st.fb_internal, st.therm_sd, st.ch_out.run, p.pg};
            end
            `BDC_OFF_IRQ_STAT: begin
               next_st.rdata = {2'h0, st.irq_stat};
            end
            `BDC_OFF_IRQ_MASK: begin
               next_st.rdata = {2'h0, st.irq_mask};
            end
            `BDC_OFF_REF: begin
               next_st.rdata = {st.ramping, st.ref_code};
            end
            default: begin
               next_st.rdata = '0;
            end
         endcase
      end

      // A new event in the clearing cycle survives the clear
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st.strap_cnt <= '0;
         st.strap_done <= 1'b0;
         st.standalone <= 1'b0;
         st.touched <= 1'b0;
         st.sync_prev <= 1'b0;
         // First edge after reset opens a switching cycle, so the phase pulses start aligned
         st.sw_cnt <= SW_LAST;
         st.ph0 <= 1'b0;
         st.ph180 <= 1'b0;
         st.therm_sd <= 1'b0;
         st.ch <= '{BDC_CH_OFF, BDC_CH_OFF, BDC_CH_OFF};
         st.cnt <= '0;
         st.ctrl_en <= `BDC_CTRL_EN_RST;
         st.ctrl_ccm <= `BDC_CTRL_CCM_RST;
         st.slew <= `BDC_SLEW_RST;
         st.target <= `BDC_VID_RST;
         st.ref_code <= `BDC_VID_RST;
         st.ramping <= 1'b0;
         st.slew_cnt <= '0;
         st.fb_internal <= 1'b0;
         st.pg_out <= 1'b0;
         st.irq_stat <= '0;
         st.irq_mask <= `BDC_IRQ_MASK_RST;
         st.irq <= 1'b0;
         st.rdata <= '0;
         st.ch_out.run <= '0;
         // Stopped channels keep the high side off and soft-start discharged
         st.ch_out.hs_off <= 3'h7;
         st.ch_out.switch_node_pulldown <= '0;
         st.ch_out.continuous_conduction_mode <= '0;
         st.ch_out.ss_hold <= 3'h7;
      end else begin
         st <= next_st;
      end
   end

   // Feedback stays on the external divider until a trigger arrives
   assign FB_INTERNAL = st.fb_internal;
   assign RDATA = st.rdata;
   assign CH = st.ch_out;
   assign SW_CLK_PH0 = st.ph0;
   assign SW_CLK_PH180 = st.ph180;
   assign REF_CODE = st.ref_code;
   assign POWER_GOOD_OUT = st.pg_out;
   assign IRQ = st.irq;
   assign STANDALONE = st.standalone;
endmodule // bdc_ctrl

// *** testbench/bdc_checker.sv ***
// Port assertions for the converter control block
`timescale 1ns/1ps
`include "bdc_map.svh"
module bdc_checker
   import bdc_pkg::*;
#(
   parameter int SW_PERIOD_CYC = 20
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire bdc_pkg::bdc_bus_t BUS,
   input wire bdc_pkg::bdc_pins_t PINS,
   input wire logic [`BDC_DATA_W-1:0] RDATA,
   input wire bdc_pkg::bdc_ch_out_t CH,
   input wire logic SW_CLK_PH0,
   input wire logic SW_CLK_PH180,
   input wire logic [6:0] REF_CODE,
   input wire logic FB_INTERNAL,
   input wire logic POWER_GOOD_OUT,
   input wire logic IRQ,
   input wire logic STANDALONE
);
   localparam int HALF = SW_PERIOD_CYC / 2;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   property p_phase; SW_CLK_PH180 |-> $past(SW_CLK_PH0, HALF); endproperty
   property p_ref_step;
      $changed(REF_CODE) |->
         (REF_CODE == $past(REF_CODE) + 7'h01) || (REF_CODE == $past(REF_CODE) - 7'h01);
   endproperty
   property p_ref_hold; $changed(REF_CODE) |-> FB_INTERNAL; endproperty
   // Feedback source only moves on a write that carries the trigger bit
   property p_fb_go;
      $rose(FB_INTERNAL) |->
         $past(BUS.wr && BUS.addr == `BDC_OFF_VID && BUS.wdata[`BDC_VID_GO_BIT]);
   endproperty
   property p_pg; POWER_GOOD_OUT |-> CH.run == 3'h7 || $past(CH.run) == 3'h7; endproperty
   property p_pulldown;
      (CH.switch_node_pulldown & ~(CH.run | $past(CH.run))) == 3'h0;
   endproperty
   property p_hs_off; (~CH.run & ~CH.hs_off) == 3'h0; endproperty
   property p_rd_idle; !$past(BUS.rd) |-> RDATA == 8'h00; endproperty
   property p_alone; STANDALONE |-> RDATA == 8'h00; endproperty
   a_phase: assert property (p_phase) else $error("late phase pulse");
   a_ref_step: assert property (p_ref_step) else $error("ref jumped");
   a_ref_hold: assert property (p_ref_hold) else $error("ref moved untriggered");
   a_fb_go: assert property (p_fb_go) else $error("feedback moved w/o trigger");
   a_pg: assert property (p_pg) else $error("power good while not running");
   a_pulldown: assert property (p_pulldown) else $error("pulldown on idle ch");
   a_hs_off: assert property (p_hs_off) else $error("high side on while off");
   a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
   a_alone: assert property (p_alone) else $error("bus answered standalone");
   c_ramp: cover property (FB_INTERNAL && $changed(REF_CODE));
   c_pg: cover property (POWER_GOOD_OUT);
   c_alone: cover property (STANDALONE);
endmodule // bdc_checker

bind bdc_ctrl bdc_checker #(.SW_PERIOD_CYC(SW_PERIOD_CYC)) u_chk (.CLK(CLK), .RESETN(RESETN),
   .BUS(BUS), .PINS(PINS), .RDATA(RDATA), .CH(CH), .SW_CLK_PH0(SW_CLK_PH0),
   .SW_CLK_PH180(SW_CLK_PH180), .REF_CODE(REF_CODE), .FB_INTERNAL(FB_INTERNAL),
   .POWER_GOOD_OUT(POWER_GOOD_OUT), .IRQ(IRQ), .STANDALONE(STANDALONE));

// *** testbench/bdc_host_model.sv ***
// Host controller model driving the register port
`timescale 1ns/1ps
module bdc_host_model
   import bdc_pkg::*;
(
   input wire logic CLK,
   input wire logic [7:0] RDATA,
   output bdc_pkg::bdc_bus_t BUS
);
   initial BUS = '0;
   // Strobe held one full cycle, so back-to-back calls still leave a gap
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge CLK);
      BUS.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLK);
      BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge CLK);
      BUS.rd <= 1'b0;
      @(negedge CLK);
      d = RDATA;
   endtask
endmodule // bdc_host_model

// *** testbench/buck_dvs_control_tb_top.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "bdc_map.svh"
module buck_dvs_control_tb_top;
   import bdc_pkg::*;
   localparam int UNIT = `BDC_SLEW_UNIT_NS / `BDC_CLK_PERIOD_NS;
   logic clk;
   logic rst_n;
   bdc_pins_t pins;
   bdc_bus_t bus;
   bdc_ch_out_t ch;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [6:0] ref_code;
   logic ph0, ph180, fb_int, power_good_out, irq, standalone, sync_run;
   int err_count, total_checks, cyc, n;
   bdc_ctrl #(.OC_WAIT_SW(4), .HICCUP_SW(16)) dut (.CLK(clk), .RESETN(rst_n), .BUS(bus),
      .PINS(pins), .RDATA(rdata), .CH(ch), .SW_CLK_PH0(ph0), .SW_CLK_PH180(ph180),
      .REF_CODE(ref_code), .FB_INTERNAL(fb_int), .POWER_GOOD_OUT(power_good_out), .IRQ(irq),
      .STANDALONE(standalone));
   bdc_host_model host (.CLK(clk), .RDATA(rdata), .BUS(bus));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // External clock, unrelated in phase; it stands still when not wanted
   initial begin
      #37;
      forever begin
         #400;
         if (sync_run) pins.sync_clk = ~pins.sync_clk;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_run(input logic [2:0] e, input int lim);
      n = 0;
      while (ch.run !== e && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(8'(ch.run), 8'(e), "run");
   endtask
   task automatic ramp(input logic [7:0] v, input logic [2:0] s, input logic [6:0] from);
      int t;
      t = ((v[6:0] > from) ? v[6:0] - from : from - v[6:0]) * (s + 1) * UNIT;
      host.wr(8'h02, {5'h00, s});
      host.wr(8'h04, 8'h20);
      host.wr(8'h01, v);
      n = 0;
      while (ref_code !== v[6:0] && n < t + 30) begin
         @(negedge clk);
         n++;
      end
      chk(8'(ref_code), {1'b0, v[6:0]}, "ref end");
      chk(8'(n >= t - (s + 1) * UNIT), 8'h01, "ramp too fast");
      chk(8'(fb_int), 8'h01, "fb internal");
      host.rd(8'h04, d);
      chk(d & 8'h20, 8'h20, "ramp done");
   endtask
   initial begin
      rst_n = 1'b0;
      sync_run = 1'b0;
      err_count = 0;
      total_checks = 0;
      cyc = 0;
      pins = '0;
      pins.sda = 1'b1;
      pins.scl = 1'b1;
      pins.sync_clk = 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(negedge clk);
      chk(8'(standalone), 8'h00, "strap");
      chk(8'(fb_int), 8'h00, "fb external");
      host.rd(8'h00, d);
      chk(d, 8'h07, "ctrl reset");
      host.rd(8'h05, d);
      chk(d, 8'h00, "mask reset");
      host.rd(8'h3f, d);
      chk(d, 8'h00, "unmapped");
      @(posedge clk);
      pins.channel_enable_pin <= 3'h7;
      pins.pg <= 3'h7;
      wait_run(3'h7, 20);
      repeat (6) @(negedge clk);
      chk(8'(power_good_out), 8'h01, "power_good_out on");
      host.rd(8'h03, d);
      chk(d, 8'h3f, "status");
      host.wr(8'h00, 8'h25);
      wait_run(3'h5, 20);
      chk(8'(ch.continuous_conduction_mode), 8'h04, "ccm");
      repeat (4) @(negedge clk);
      chk(8'(power_good_out), 8'h00, "power_good_out ch off");
      host.wr(8'h00, 8'h07);
      wait_run(3'h7, 20);
      @(posedge clk);
      pins.pg <= 3'h5;
      pins.ov[1] <= 1'b1;
      pins.bst_uv[2] <= 1'b1;
      repeat (8) @(negedge clk);
      host.rd(8'h03, d);
      chk(d, 8'h3d, "status pg");
      chk(8'(power_good_out), 8'h00, "power_good_out range");
      chk(8'(ch.hs_off), 8'h02, "hs off");
      chk(8'(ch.switch_node_pulldown), 8'h04, "pulldown");
      @(posedge clk);
      pins.pg <= 3'h7;
      pins.ov[1] <= 1'b0;
      pins.bst_uv[2] <= 1'b0;
      repeat (8) @(negedge clk);
      chk(8'(ch.hs_off), 8'h00, "hs released");
      host.wr(8'h01, 8'h05);
      repeat (30) @(negedge clk);
      chk(8'(ref_code), 8'h00, "code alone");
      chk(8'(fb_int), 8'h00, "fb unchanged");
      ramp(8'h85, 3'h0, 7'h00);
      ramp(8'hff, 3'h0, 7'h05);
      ramp(8'h80, 3'h1, 7'h7f);
      host.wr(8'h05, 8'h20);
      repeat (3) @(negedge clk);
      chk(8'(irq), 8'h01, "irq raised");
      host.wr(8'h05, 8'h00);
      repeat (3) @(negedge clk);
      chk(8'(irq), 8'h00, "irq masked");
      host.wr(8'h04, 8'h3f);
      host.wr(8'h05, 8'h20);
      repeat (3) @(negedge clk);
      chk(8'(irq), 8'h00, "irq cleared");
      @(posedge clk);
      pins.oc[0] <= 1'b1;
      wait_run(3'h6, 6 * 20 + 10);
      chk(8'(n >= 4 * 20 - 2), 8'h01, "oc wait");
      @(posedge clk);
      pins.oc[0] <= 1'b0;
      wait_run(3'h7, 16 * 20 + 60);
      chk(8'(n >= 15 * 20), 8'h01, "hiccup");
      host.rd(8'h04, d);
      chk(d & 8'h01, 8'h01, "oc flag");
      @(posedge clk);
      pins.therm_hot <= 1'b1;
      wait_run(3'h0, 20);
      @(posedge clk);
      pins.therm_hot <= 1'b0;
      repeat (20) @(negedge clk);
      chk(8'(ch.run), 8'h00, "still hot");
      @(posedge clk);
      pins.therm_cool <= 1'b1;
      wait_run(3'h7, 20);
      chk(8'(ch.ss_hold), 8'h00, "soft start");
      @(posedge clk);
      pins.therm_cool <= 1'b0;
      @(posedge ph0);
      n = 0;
      // Count from the cycle in which the start pulse stands
      @(negedge clk);
      while (ph180 !== 1'b1 && n < 30) begin
         @(negedge clk);
         n++;
      end
      chk(8'(n), 8'd10, "phase gap");
      sync_run = 1'b1;
      repeat (3) begin
         @(negedge pins.sync_clk);
         n = 0;
         while (ph0 !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
         end
         chk(8'(n < 8), 8'h01, "sync lock");
      end
      sync_run = 1'b0;
      @(posedge clk);
      pins.sda <= 1'b0;
      pins.scl <= 1'b0;
      pins.channel_enable_pin <= 3'h2;
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(negedge clk);
      chk(8'(standalone), 8'h01, "standalone");
      wait_run(3'h2, 20);
      host.wr(8'h01, 8'h85);
      host.rd(8'h00, d);
      chk(d, 8'h00, "bus ignored");
      chk(8'(fb_int), 8'h00, "fb stays ext");
      results();
   end
endmodule // buck_dvs_control_tb_top
